// ==== flash_ctrl_regs.svh ====
// Purpose: addresses, fields, reset values and timing counts
// Assumes: 250 MHz system clock
// Notes:   definitions only
`ifndef FLASH_CTRL_REGS_SVH
`define FLASH_CTRL_REGS_SVH
// cpu bus addresses
`define FC_ADR_MODE_CTL   16'hFF80
`define FC_ADR_LARGE_SEL  16'hFF82
`define FC_ADR_SMALL_SEL  16'hFF83
`define FC_ADR_WAIT_CTL   16'hFFC2
`define FC_FLASH_END_M2   16'hEF7F
`define FC_FLASH_END_M3   16'hF77F
`define FC_ODD_BYTE       16'h0001
// ram overlay windows
`define FC_OVL_BASE0      16'hE000
`define FC_OVL_BASE1      16'hE400
`define FC_OVL_MASK       16'hFC00
// reset and fill values
`define FC_RST_MODE_CTL   4'h0
`define FC_RST_BLOCK      8'h00
`define FC_RST_WAIT       8'h08
`define FC_RSV_READ       8'hFF
`define FC_ZERO_BYTE      8'h00
// field positions
`define FC_BIT_OVL_EN     7
`define FC_BIT_OVL_SEL    6
`define FC_BIT_ECHK       3
`define FC_BIT_WCHK       2
`define FC_BIT_E          1
`define FC_BIT_P          0
// boot rate match: host sends a zero byte, start plus eight low bits
`define FC_CLK_MHZ        250
`define FC_BOOT_LOW_BITS  9
`define FC_BOOT_MAX_BPS   9600
`define FC_BOOT_MIN_LOW   ((`FC_CLK_MHZ * 1000000 / `FC_BOOT_MAX_BPS) * `FC_BOOT_LOW_BITS)
// host timing, times in their own unit then cycles
`define FC_VS1_US         4
`define FC_VS2_US         2
`define FC_PROG_MAX_US    1000
`define FC_ERASE_MAX_S    30
`define FC_READ_SETUP_US  50
`define FC_VS1_CYC        (`FC_VS1_US * `FC_CLK_MHZ)
`define FC_VS2_CYC        (`FC_VS2_US * `FC_CLK_MHZ)
`define FC_PROG_MAX_CYC   (`FC_PROG_MAX_US * `FC_CLK_MHZ)
`define FC_ERASE_MAX_CYC  (64'd1000000 * `FC_ERASE_MAX_S * `FC_CLK_MHZ)
`define FC_READ_SETUP_CYC (`FC_READ_SETUP_US * `FC_CLK_MHZ)
// host wishbone register offsets
`define FC_WB_ADDR        8'h00
`define FC_WB_WDATA       8'h04
`define FC_WB_CMD         8'h08
`define FC_WB_STATUS      8'h0C
`define FC_WB_PULSE       8'h10
`endif

// ==== flash_ctrl_pkg.sv ====
// Purpose: shared types of both ends
// Assumes: constants live in flash_ctrl_regs.svh
// Notes:   state of each module is one packed struct
package flash_ctrl_pkg;
   // where one byte address lands
   typedef enum logic [2:0] {
      RG_EXT   = 3'h0,
      RG_FLASH = 3'h1,
      RG_OVL   = 3'h2,
      RG_RSV   = 3'h3,
      RG_CTL   = 3'h4,
      RG_LBS   = 3'h5,
      RG_SBS   = 3'h6,
      RG_WAIT  = 3'h7
   } region_t;
   // mode pins, high pin first
   typedef enum logic [1:0] {
      MD_ILLEGAL = 2'h0,
      MD_EXT     = 2'h1,
      MD_FLASH_S = 2'h2,
      MD_FLASH_L = 2'h3
   } chip_mode_t;
   // flash array operation in force
   typedef enum logic [2:0] {
      OP_NONE, OP_PROGRAM, OP_PROG_VERIFY, OP_ERASE, OP_ERASE_VERIFY, OP_PREWRITE_VERIFY
   } flash_op_t;
   // device bus states, gray along idle, t1, t2
   typedef enum logic [1:0] {BS_IDLE = 2'b00, BS_T1 = 2'b01, BS_T2 = 2'b11} bus_state_t;
   // host sequencer states, gray ring
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00, HS_GAP = 2'b01, HS_BUS = 2'b11, HS_PULSE = 2'b10
   } host_state_t;
   // host command kinds
   typedef enum logic [1:0] {
      HOP_SINGLE = 2'h0, HOP_POLL = 2'h1, HOP_PULSE = 2'h2, HOP_RSV = 2'h3
   } host_op_t;
   typedef struct packed {
      bus_state_t  st;
      logic [4:0]  sync1;
      logic [4:0]  sync2;
      logic [3:0]  mode_ctl;
      logic [7:0]  large_sel;
      logic [7:0]  small_sel;
      logic [7:0]  wait_ctl;
      logic [15:0] rdata;
      region_t     region;
      logic        ext;
      logic        rx_prev;
      logic [23:0] boot_cnt;
      logic [23:0] boot_low;
      logic        boot_lock;
   } dev_state_t;
   typedef struct packed {
      host_state_t st;
      logic [15:0] adr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic        wr;
      logic        word;
      host_op_t    op;
      logic        phase;
      logic        ext;
      logic        refused;
      logic [31:0] pulse_len;
      logic [32:0] cnt;
      logic [31:0] gap;
      logic        req;
      logic        wb_ack;
      logic [31:0] wb_dat;
   } host_state_q_t;
endpackage

// ==== flash_bus_if.sv ====
// Purpose: cpu bus between flash control host and device
// Assumes: one clock, req held until ack
// Notes:   word data is high byte at the even address
`timescale 1ns/1ns
interface flash_bus_if;
   logic        req;    // access request, level
   logic        wr;     // write when high
   logic        word;   // 16-bit access when high
   logic [15:0] addr;   // byte address
   logic [15:0] wdata;  // write data
   logic [15:0] rdata;  // read data
   logic        ack;    // access done, one cycle
   logic        ext;    // access routed outside
   modport dev  (input req, wr, word, addr, wdata, output rdata, ack, ext);
   modport host (output req, wr, word, addr, wdata, input rdata, ack, ext);
endinterface

// ==== flash_addr_decode.sv ====
// Purpose: resolve one byte address to its region
// Assumes: mode and voltage flag already synchronised
// Notes:   purely combinational, same cycle
`timescale 1ns/1ns
`include "flash_ctrl_regs.svh"
module flash_addr_decode
   import flash_ctrl_pkg::*;
(
   input  wire logic [15:0] addr,
   input  wire chip_mode_t  mode,
   input  wire logic        hv,
   input  wire logic        ovl_en,
   input  wire logic        ovl_sel,
   output region_t          region
);
   logic [15:0] ovl_base;  // chosen overlay window
   logic        in_flash;  // address inside on-chip flash

   // decode from pins and flag, no wait state [RULE23]
   always_comb
   begin
      ovl_base = ovl_sel ? `FC_OVL_BASE1 : `FC_OVL_BASE0;
      in_flash = ((mode == MD_FLASH_S) && (addr <= `FC_FLASH_END_M2)) ||  // [RULE4] [RULE5]
                 ((mode == MD_FLASH_L) && (addr <= `FC_FLASH_END_M3));
      region = RG_EXT;
      if ((addr >= `FC_ADR_MODE_CTL) && (addr <= `FC_ADR_SMALL_SEL))
      begin
         if (mode == MD_EXT)
            region = hv ? RG_RSV : RG_EXT;  // flash disabled [RULE8]
         else if (mode == MD_ILLEGAL)
            region = RG_RSV;  // illegal pins, read fill [RULE5]
         else if (!hv)
            region = (mode == MD_FLASH_S) ? RG_EXT : RG_RSV;  // [RULE7] [RULE2] [RULE10]
         else if (addr == `FC_ADR_MODE_CTL)
            region = RG_CTL;  // [RULE1]
         else if (addr == `FC_ADR_LARGE_SEL)
            region = RG_LBS;
         else if (addr == `FC_ADR_SMALL_SEL)
            region = RG_SBS;
         else
            region = RG_RSV;  // gap byte
      end
      else if (addr == `FC_ADR_WAIT_CTL)
         region = RG_WAIT;  // [RULE19]
      else if (in_flash)
         region = (ovl_en && ((addr & `FC_OVL_MASK) == ovl_base)) ? RG_OVL : RG_FLASH;  // [RULE18]
   end
endmodule

// ==== flash_ctrl_device.sv ====
// Purpose: flash control registers and access gating of the device end
// Assumes: pins are asynchronous; cpu bus is on CLK_SYS
// Notes:   array data comes from outside on ARRAY_RDATA
//
// Behaviour
// RULE1 - with voltage, single-chip mode ff80 is control
// RULE2 - without voltage, single-chip ff80 reads ff, ignores writes
// RULE3 - software polls ff80 byte until not ff
// RULE4 - flash ends ef7f mode 2, f77f mode 3
// RULE5 - mode pins: 00 illegal, 01/10/11 modes
// RULE6 - 16-bit path, two states per access
// RULE7 - mode 2 without voltage: ff80-ff83 external
// RULE8 - mode 1: control registers read ff, fixed; code reads ff only with voltage, without it ff80-ff83 go outside
// RULE9 - modes 2 and 3: registers start at 00
// RULE10 - registers reachable only with programming voltage
// RULE11 - software waits verify setup 4 and 2 us
// RULE12 - program pulse typically 50, at most 1000 us
// RULE13 - erase bit at most 30 seconds
// RULE14 - wait 50 us before reading flash
// RULE15 - five operating modes of the array
// RULE16 - eight large, eight small erase blocks
// RULE17 - boot mode matches host bit rate
// RULE18 - ram may overlay part of flash
// RULE19 - wait control register ff c2, reset 08
// RULE20 - control bit 7 shows voltage, read only
// RULE21 - control bits 3..0 select four modes
// RULE22 - software sets one mode bit at most
// RULE23 - decode resolves within the same bus cycle
`timescale 1ns/1ns
`include "flash_ctrl_regs.svh"
module flash_ctrl_device
   import flash_ctrl_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        RSTN,
   flash_bus_if.dev         BUS,
   input  wire logic        MODE_SELECT_HIGH,
   input  wire logic        MODE_SELECT_LOW,
   input  wire logic        PROGRAMMING_SUPPLY_PIN,
   input  wire logic        BOOT_MODE,
   input  wire logic        BOOT_SERIAL_IN,
   input  wire logic [15:0] ARRAY_RDATA,
   output region_t          ACCESS_REGION,
   output logic             ACCESS_BUSY,
   output flash_op_t        FLASH_OP,
   output logic [7:0]       LARGE_BLOCK_SEL,
   output logic [7:0]       SMALL_BLOCK_SEL,
   output logic [7:0]       WAIT_CONTROL,
   output logic             OVERLAY_ACTIVE,
   output logic             ILLEGAL_MODE,
   output logic [23:0]      BOOT_LOW_CYCLES,
   output logic             BOOT_RATE_LOCKED
);
   dev_state_t  q;        // all registered state
   dev_state_t  d;        // next state
   chip_mode_t  mode;     // synchronised mode pins
   logic        hv;       // synchronised voltage flag
   logic        boot;     // synchronised boot strap
   logic        rx;       // synchronised serial input
   logic [15:0] adr_lo;   // odd byte of a word access
   region_t     rg_hi;    // region of the addressed byte
   region_t     rg_lo;    // region of the odd byte
   logic [7:0]  rd_hi;    // read byte, addressed
   logic [7:0]  rd_lo;    // read byte, odd
   logic [3:0]  mbits;    // mode bits for decoding

   // second stage of the pin synchronisers only
   assign mode   = chip_mode_t'(q.sync2[1:0]);
   assign hv     = q.sync2[2];
   assign rx     = q.sync2[3];
   assign boot   = q.sync2[4];
   assign adr_lo = BUS.addr | `FC_ODD_BYTE;
   assign mbits  = q.mode_ctl;

   // region of the addressed byte
   flash_addr_decode u_dec_hi (
      .addr    (BUS.addr),
      .mode    (mode),
      .hv      (hv),
      .ovl_en  (q.wait_ctl[`FC_BIT_OVL_EN]),
      .ovl_sel (q.wait_ctl[`FC_BIT_OVL_SEL]),
      .region  (rg_hi)
   );

   // region of the second byte of a word
   flash_addr_decode u_dec_lo (
      .addr    (adr_lo),
      .mode    (mode),
      .hv      (hv),
      .ovl_en  (q.wait_ctl[`FC_BIT_OVL_EN]),
      .ovl_sel (q.wait_ctl[`FC_BIT_OVL_SEL]),
      .region  (rg_lo)
   );

   // value one byte reads as
   function automatic logic [7:0] rd_byte(input region_t r, input logic [7:0] arr,
                                          input logic v, input dev_state_t s);
      case (r)
         RG_CTL:  rd_byte = {v, 3'b000, s.mode_ctl};  // live flag, reserved zero [RULE20]
         RG_LBS:  rd_byte = s.large_sel;
         RG_SBS:  rd_byte = s.small_sel;
         RG_WAIT: rd_byte = s.wait_ctl;
         RG_RSV:  rd_byte = `FC_RSV_READ;  // [RULE2] [RULE8]
         default: rd_byte = arr;  // flash, overlay ram or outside
      endcase
   endfunction

   // read bytes of the current access
   always_comb
   begin
      rd_hi = rd_byte(rg_hi, BUS.word ? ARRAY_RDATA[15:8] : ARRAY_RDATA[7:0], hv, q);
      rd_lo = rd_byte(rg_lo, ARRAY_RDATA[7:0], hv, q);
   end

   // next state of the whole device end
   always_comb
   begin
      d = q;
      d.sync1 = {BOOT_MODE, BOOT_SERIAL_IN, PROGRAMMING_SUPPLY_PIN,
                 MODE_SELECT_HIGH, MODE_SELECT_LOW};
      d.sync2 = q.sync1;
      // registers fall back to initial value when unreachable
      if (!hv || (mode == MD_EXT) || (mode == MD_ILLEGAL))
      begin
         d.mode_ctl  = `FC_RST_MODE_CTL;  // [RULE9] [RULE10]
         d.large_sel = `FC_RST_BLOCK;
         d.small_sel = `FC_RST_BLOCK;
      end
      // two-state bus cycle [RULE6]
      case (q.st)
         BS_IDLE:
         begin
            if (BUS.req)
            begin
               d.st     = BS_T1;
               d.region = rg_hi;
            end
         end
         BS_T1:
         begin
            d.st  = BS_T2;
            d.ext = (rg_hi == RG_EXT);  // [RULE7]
            if (BUS.word)
               d.rdata = {rd_hi, rd_lo};  // 16-bit path [RULE6]
            else
               d.rdata = {`FC_ZERO_BYTE, rd_hi};
         end
         BS_T2:
         begin
            d.st = BS_IDLE;
            if (BUS.wr)
            begin
               // writes take effect at the ack edge
               case (rg_hi)
                  RG_CTL:  d.mode_ctl  = BUS.word ? BUS.wdata[11:8] : BUS.wdata[3:0];  // [RULE21]
                  RG_LBS:  d.large_sel = BUS.word ? BUS.wdata[15:8] : BUS.wdata[7:0];  // [RULE16]
                  RG_SBS:  d.small_sel = BUS.wdata[7:0];  // [RULE16]
                  RG_WAIT: d.wait_ctl  = BUS.word ? BUS.wdata[15:8] : BUS.wdata[7:0];  // [RULE19]
                  default: d.wait_ctl  = q.wait_ctl;  // reserved and outside ignored
               endcase
               if (BUS.word && (rg_lo == RG_SBS))
                  d.small_sel = BUS.wdata[7:0];  // word at ff82 fills both
            end
         end
         default: d.st = BS_IDLE;
      endcase
      // boot rate match on the low time of a zero byte [RULE17]
      d.rx_prev = rx;
      if (!boot)
      begin
         d.boot_cnt  = 24'h000000;
         d.boot_lock = 1'b0;
      end
      else if (q.rx_prev && !rx)
         d.boot_cnt = 24'h000000;  // start bit edge
      else if (!rx && (q.boot_cnt != 24'hFFFFFF))
         d.boot_cnt = q.boot_cnt + 24'h000001;  // saturating count
      else if (!q.rx_prev && rx && !q.boot_lock && (q.boot_cnt >= 24'(`FC_BOOT_MIN_LOW)))
      begin
         d.boot_low  = q.boot_cnt;  // faster than the limit is ignored
         d.boot_lock = 1'b1;
      end
   end

   // one register stage for all state
   always_ff @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
      begin
         q          <= '0;
         q.st       <= BS_IDLE;
         q.region   <= RG_EXT;
         q.mode_ctl <= `FC_RST_MODE_CTL;  // [RULE9]
         q.wait_ctl <= `FC_RST_WAIT;  // [RULE19]
         q.rx_prev  <= 1'b1;
      end
      else
         q <= d;
   end

   // single mode bit selects the array operation [RULE15] [RULE21]
   always_comb
   begin
      case (mbits)
         4'h1:    FLASH_OP = OP_PROGRAM;
         4'h2:    FLASH_OP = OP_ERASE;
         4'h4:    FLASH_OP = ((q.large_sel | q.small_sel) != `FC_RST_BLOCK) ?
                             OP_PREWRITE_VERIFY : OP_PROG_VERIFY;
         4'h8:    FLASH_OP = OP_ERASE_VERIFY;
         default: FLASH_OP = OP_NONE;  // none or several bits
      endcase
   end

   // bus answers and status from flops
   assign BUS.ack          = (q.st == BS_T2);
   assign BUS.rdata        = q.rdata;
   assign BUS.ext          = q.ext;
   assign ACCESS_REGION    = q.region;
   assign ACCESS_BUSY      = (q.st != BS_IDLE);
   assign LARGE_BLOCK_SEL  = q.large_sel;
   assign SMALL_BLOCK_SEL  = q.small_sel;
   assign WAIT_CONTROL     = q.wait_ctl;
   assign OVERLAY_ACTIVE   = q.wait_ctl[`FC_BIT_OVL_EN];  // [RULE18]
   assign ILLEGAL_MODE     = (q.sync2[1:0] == MD_ILLEGAL);
   assign BOOT_LOW_CYCLES  = q.boot_low;
   assign BOOT_RATE_LOCKED = q.boot_lock;
endmodule

// ==== flash_ctrl_host.sv ====
// Purpose: programming host driving the device bus from wishbone commands
// Assumes: classic wishbone slave on CLK_SYS
// Notes:   long waits are parameters so simulation can shorten them
`timescale 1ns/1ns
`include "flash_ctrl_regs.svh"
module flash_ctrl_host
   import flash_ctrl_pkg::*;
#(
   parameter logic [32:0] PROG_MAX_CYC   = 33'(`FC_PROG_MAX_CYC),
   parameter logic [32:0] ERASE_MAX_CYC  = 33'(`FC_ERASE_MAX_CYC),
   parameter logic [31:0] READ_SETUP_CYC = 32'(`FC_READ_SETUP_CYC)
)
(
   input  wire logic        CLK_SYS,
   input  wire logic        RSTN,
   flash_bus_if.host        BUS,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [31:0] WB_DAT_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic        WB_WE_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_CYC_I,
   output logic [31:0]      WB_DAT_O,
   output logic             WB_ACK_O
);
   host_state_q_t q;       // all registered state
   host_state_q_t d;       // next state
   logic          hit;     // wishbone cycle present
   logic          wr_now;  // write at the ack edge
   logic [31:0]   wmask;   // byte lanes of the write
   logic [3:0]    nb;      // mode bits being written

   // merge written lanes into a register
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [31:0] m);
      merge = (o & ~m) | (n & m);
   endfunction

   always_comb
   begin
      hit    = WB_CYC_I && WB_STB_I;
      wr_now = hit && q.wb_ack && WB_WE_I;
      wmask  = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
      nb     = q.wdata[3:0];
      d = q;
      d.wb_ack = hit && !q.wb_ack;
      if (q.gap != 32'h0)
         d.gap = q.gap - 32'h1;
      // registered read data, unmapped reads zero
      if (hit && !q.wb_ack)
         case (WB_ADR_I)
            `FC_WB_ADDR:   d.wb_dat = {16'h0000, q.adr};
            `FC_WB_WDATA:  d.wb_dat = {16'h0000, q.wdata};
            `FC_WB_STATUS: d.wb_dat = {q.rdata, 13'h0000, q.refused, q.ext, q.st != HS_IDLE};
            `FC_WB_PULSE:  d.wb_dat = q.pulse_len;
            default:       d.wb_dat = 32'h0;
         endcase
      if (wr_now)
         case (WB_ADR_I)
            `FC_WB_ADDR:  d.adr = 16'(merge({16'h0000, q.adr}, WB_DAT_I, wmask));
            `FC_WB_WDATA: d.wdata = 16'(merge({16'h0000, q.wdata}, WB_DAT_I, wmask));
            `FC_WB_PULSE: d.pulse_len = merge(q.pulse_len, WB_DAT_I, wmask);
            `FC_WB_CMD:
            begin
               d.op    = host_op_t'(WB_DAT_I[3:2]);
               d.wr    = WB_DAT_I[0];
               d.word  = WB_DAT_I[1];
               d.phase = 1'b0;
               d.refused = 1'b0;
               if (q.st != HS_IDLE || !WB_SEL_I[0] || WB_DAT_I[3:2] == HOP_RSV)
                  d.refused = 1'b1;  // busy or unknown command
               else if (WB_DAT_I[0] && q.adr == `FC_ADR_MODE_CTL && (nb & (nb - 4'h1)) != 4'h0)
                  d.refused = 1'b1;  // more than one mode bit [RULE22]
               else
                  d.st = HS_GAP;
               if (WB_DAT_I[3:2] == HOP_POLL)
               begin
                  d.adr  = `FC_ADR_MODE_CTL;  // byte read of ff80
                  d.wr   = 1'b0;
                  d.word = 1'b0;
               end
            end
            default: d.wb_dat = q.wb_dat;
         endcase
      case (q.st)
         HS_IDLE: d.req = 1'b0;
         HS_GAP:
            if (q.gap == 32'h0)
            begin
               d.st  = HS_BUS;  // settle times have passed [RULE11] [RULE14]
               d.req = 1'b1;
            end
         HS_BUS:
            if (BUS.ack)
            begin
               d.req   = 1'b0;
               d.rdata = BUS.rdata;
               d.ext   = BUS.ext;
               d.st    = HS_IDLE;
               if (q.wr && q.adr == `FC_ADR_MODE_CTL &&
                   (q.wdata[`FC_BIT_WCHK] || q.wdata[`FC_BIT_ECHK]))
                  d.gap = 32'(`FC_VS1_CYC);  // [RULE11]
               else if (q.wr && q.adr < `FC_ADR_MODE_CTL)
                  d.gap = 32'(`FC_VS2_CYC);  // [RULE11]
               if (q.op == HOP_POLL && BUS.rdata[7:0] == `FC_RSV_READ)
                  d.st = HS_GAP;  // whole byte compare [RULE3]
               else if (q.op == HOP_PULSE && !q.phase)
               begin
                  d.st  = HS_PULSE;
                  d.cnt = {1'b0, q.pulse_len};
                  if (q.wdata[`FC_BIT_P] && ({1'b0, q.pulse_len} > PROG_MAX_CYC))
                     d.cnt = PROG_MAX_CYC;  // [RULE12]
                  if (q.wdata[`FC_BIT_E] && ({1'b0, q.pulse_len} > ERASE_MAX_CYC))
                     d.cnt = ERASE_MAX_CYC;  // [RULE13]
               end
            end
         HS_PULSE:
            if (q.cnt == 33'h0)
            begin
               d.wdata = 16'h0000;  // drop the mode bit
               d.phase = 1'b1;
               d.st    = HS_GAP;
            end
            else
               d.cnt = q.cnt - 33'h1;
         default: d.st = HS_IDLE;
      endcase
   end

   // one register stage; read setup wait after reset [RULE14]
   always_ff @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
      begin
         q     <= '0;
         q.st  <= HS_IDLE;
         q.op  <= HOP_SINGLE;
         q.gap <= READ_SETUP_CYC;
      end
      else
         q <= d;
   end

   assign BUS.req   = q.req;
   assign BUS.wr    = q.wr;
   assign BUS.word  = q.word;
   assign BUS.addr  = q.adr;
   assign BUS.wdata = q.wdata;
   assign WB_DAT_O  = q.wb_dat;
   assign WB_ACK_O  = q.wb_ack;
endmodule

// ==== flash_bus_properties.sv ====
// Purpose: timing checks on the cpu bus between host and device
// Assumes: one clock, reset async active low
// Notes:   sees only the interface signals
`timescale 1ns/1ns
module flash_bus_properties (
   input wire logic        CLK_SYS,
   input wire logic        RSTN,
   input wire logic        req,
   input wire logic        wr,
   input wire logic        word,
   input wire logic [15:0] addr,
   input wire logic [15:0] rdata,
   input wire logic        ack,
   input wire logic        ext
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   // request cycle and t1 pass quietly, then one ack in t2
   sequence s_states; !ack ##1 !ack; endsequence
   sequence s_answer; ack ##1 !ack; endsequence
   property p_two_state; $rose(req) |-> s_states ##1 s_answer; endproperty
   a_two_state: assert property (p_two_state) else $error("ack not two states after req");
   property p_pulse; ack |=> !ack; endproperty
   a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
   property p_hold; req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(word); endproperty
   a_hold: assert property (p_hold) else $error("request changed before ack");
   property p_release; ack |=> !req; endproperty
   a_release: assert property (p_release) else $error("req kept after ack");
   property p_ack_req; ack |-> req && $past(req) && $past(req, 2); endproperty
   a_ack_req: assert property (p_ack_req) else $error("ack without held req");
   property p_byte_hi; ack && !wr && !word |-> rdata[15:8] == 8'h00; endproperty
   a_byte_hi: assert property (p_byte_hi) else $error("byte read high lane not zero");
   property p_keep; ack |=> $stable(rdata) && $stable(ext); endproperty
   a_keep: assert property (p_keep) else $error("read data moved after ack");
   property p_wait_int; ack && addr == 16'hFFC2 |-> !ext; endproperty
   a_wait_int: assert property (p_wait_int) else $error("wait control went outside");
endmodule

// ==== tb.sv ====
// Purpose: host and device joined, driven over wishbone and pins
// Assumes: 250 MHz clock, shortened host waits
// Notes:   results read back through host status and device outputs
`timescale 1ns/1ns
module tb import flash_ctrl_pkg::*;;
   logic        clk_sys = 1'b0; // system clock
   logic        rstn = 1'b0;    // reset, active low
   logic [1:0]  md = 2'h3;      // mode pins, high first
   logic        hv = 1'b0;      // voltage detected
   logic [7:0]  adr = 8'h00;    // wishbone address
   logic [31:0] dat = 32'h0;    // wishbone write data
   logic        we = 1'b0;      // wishbone write
   logic        stb = 1'b0;     // wishbone strobe
   logic        cyc = 1'b0;     // wishbone cycle
   logic [31:0] dat_o, rd;      // wishbone read data, last read
   logic        ack_o, illegal; // wishbone ack, bad mode
   logic        boot = 1'b0, rxd = 1'b1, lock; // boot pin, serial in, lock
   region_t     region;         // region of last access
   flash_op_t   fop;            // operation in force
   logic [7:0]  lbs, sbs, wctl; // block selects, wait control
   int          error_cnt = 0;
   int          n_checks = 0;
   int          ecnt = 0;
   logic [20:0] tbl [4] = '{{2'h2, 16'hEF7F, RG_FLASH}, {2'h2, 16'hF000, RG_EXT},
                            {2'h3, 16'hF000, RG_FLASH}, {2'h1, 16'h0000, RG_EXT}};
   flash_bus_if bus ();
   // free running clock
   always #2 clk_sys = ~clk_sys;
   // erase cycles
   always @(posedge clk_sys)
      ecnt <= ecnt + int'(fop == OP_ERASE);
   flash_ctrl_device u_flash_ctrl_device (.CLK_SYS(clk_sys), .RSTN(rstn), .BUS(bus.dev),
      .MODE_SELECT_HIGH(md[1]), .MODE_SELECT_LOW(md[0]), .PROGRAMMING_SUPPLY_PIN(hv),
      .BOOT_MODE(boot), .BOOT_SERIAL_IN(rxd), .ARRAY_RDATA(16'h1234),
      .ACCESS_REGION(region), .ACCESS_BUSY(), .FLASH_OP(fop), .LARGE_BLOCK_SEL(lbs),
      .SMALL_BLOCK_SEL(sbs), .WAIT_CONTROL(wctl), .OVERLAY_ACTIVE(), .ILLEGAL_MODE(illegal),
      .BOOT_LOW_CYCLES(), .BOOT_RATE_LOCKED(lock));
   flash_ctrl_host #(.PROG_MAX_CYC(33'd50), .ERASE_MAX_CYC(33'd80), .READ_SETUP_CYC(32'd10))
      u_flash_ctrl_host (.CLK_SYS(clk_sys), .RSTN(rstn), .BUS(bus.host), .WB_ADR_I(adr),
      .WB_DAT_I(dat), .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_STB_I(stb), .WB_CYC_I(cyc),
      .WB_DAT_O(dat_o), .WB_ACK_O(ack_o));
   flash_bus_properties u_flash_bus_properties (.CLK_SYS(clk_sys), .RSTN(rstn),
      .req(bus.req), .wr(bus.wr), .word(bus.word), .addr(bus.addr), .rdata(bus.rdata),
      .ack(bus.ack), .ext(bus.ext));
   // one classic wishbone cycle, entered right after an edge
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      adr <= a;
      we <= w;
      dat <= d;
      stb <= 1'b1;
      cyc <= 1'b1;
      @(posedge clk_sys);
      while (ack_o !== 1'b1)
         @(posedge clk_sys);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_sys);
   endtask
   // device access via host, poll till idle
   task automatic op(input logic [15:0] a, input logic [15:0] d, input logic [3:0] c);
      wb(8'h00, 1'b1, {16'h0, a});
      wb(8'h04, 1'b1, {16'h0, d});
      wb(8'h08, 1'b1, {28'h0, c});
      rd = 32'h1;
      while (rd[0] !== 1'b0)
         wb(8'h0C, 1'b0, 32'h0);
   endtask
   // pin change, then time for the synchronisers
   task automatic pins(input logic [1:0] m, input logic v);
      md <= m;
      hv <= v;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk("wait ctl", 32'h08, {24'h0, wctl});
      op(16'hFF80, 16'h0001, 4'h1);
      op(16'hFF80, 16'h0000, 4'h0);
      chk("ctl no hv", 32'h00FF, {16'h0, rd[31:16]});
      fork
         op(16'hFF80, 16'h0000, 4'h4);
         begin
            repeat (200) @(posedge clk_sys);
            hv <= 1'b1;
         end
      join
      chk("ctl poll", 32'h0080, {16'h0, rd[31:16]});
      op(16'hFF82, 16'h5A3C, 4'h3);
      chk("block sel", 32'h5A3C, {16'h0, lbs, sbs});
      op(16'hFF80, 16'h0001, 4'h1);
      chk("op", {29'h0, OP_PROGRAM}, {29'h0, fop});
      op(16'hFF80, 16'h0000, 4'h0);
      chk("ctl prog", 32'h0081, {16'h0, rd[31:16]});
      op(16'hFF80, 16'h0003, 4'h1);
      chk("refused", 32'h1, {31'h0, rd[2]});
      op(16'hFF80, 16'h0000, 4'h1);
      wb(8'h10, 1'b1, 32'h64);
      op(16'hFF80, 16'h0002, 4'h9);
      chk("erase", 32'h1, {31'h0, ecnt inside {[80:90]}});
      pins(2'h3, 1'b0);
      chk("large clr", 32'h00, {24'h0, lbs});
      pins(2'h2, 1'b0);
      op(16'hFF82, 16'h0000, 4'h0);
      chk("ext m2", 32'h1, {31'h0, rd[1]});
      pins(2'h1, 1'b1);
      op(16'hFF80, 16'h0000, 4'h0);
      chk("ctl m1", 32'h00FF, {16'h0, rd[31:16]});
      pins(2'h0, 1'b0);
      chk("illegal", 32'h1, {31'h0, illegal});
      op(16'hFFC2, 16'h0000, 4'h0);
      chk("wait rd", 32'h08, {16'h0, rd[31:16]});
      foreach (tbl[i])
      begin
         pins(tbl[i][20:19], 1'b0);
         op(tbl[i][18:3], 16'h0000, 4'h0);
         chk("region", {29'h0, tbl[i][2:0]}, {29'h0, region});
      end
      boot <= 1'b1;
      rxd <= 1'b0;
      pins(2'h1, 1'b0);
      rxd <= 1'b1;
      pins(2'h1, 1'b0);
      chk("boot fast", 32'h0, {31'h0, lock});
      wb(8'h14, 1'b0, 32'h0);
      chk("unmapped", 32'h0, rd);
      stop_test;
   end
   // hang guard
   initial
   begin
      #400000;
      error_cnt++;
      stop_test;
   end
endmodule
